// ===== hdl/stc_pkg.sv
// Constants and encodings shared by the striped track controller.
package stc_pkg;

  // ---------------------------------------------------------------
  // Field widths
  // ---------------------------------------------------------------
  localparam int CYL_W   = 11;
  localparam int HEAD_W  = 4;
  localparam int SECT_W  = 6;
  localparam int PSECT_W = 4;
  localparam int SPIN_W  = 3;
  localparam int WOFF_W  = 9;
  localparam int BEAT_W  = 10;
  localparam int ADDR_W  = SECT_W + WOFF_W;
  localparam int WORD_W  = 64;
  localparam int CHK_W   = 8;
  localparam int CW_W    = WORD_W + CHK_W;
  localparam int DST_W   = 8;
  localparam int STS_W   = 16;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam logic [CYL_W-1:0]  NUM_CYL       = 11'h663;
  localparam logic [HEAD_W-1:0] NUM_HEADS     = 4'hF;
  localparam logic [SECT_W:0]   NUM_SECT      = 7'h30;
  localparam logic [SECT_W-1:0] SECT_PER_SPIN = 6'h0C;
  localparam logic [SPIN_W-1:0] SPIN_PER_UNIT = 3'h4;
  localparam int                TRACK_WORDS   = 32'h0000_6000;
  localparam logic [BEAT_W-1:0] BLK_WORDS     = 10'h200;
  localparam int                FILL_BYTES    = 32'h0000_0010;
  localparam int                WORD_BYTES    = 32'h0000_0008;
  localparam logic [BEAT_W-1:0] FILL_BEATS    =
    BEAT_W'(FILL_BYTES / WORD_BYTES);

  // ---------------------------------------------------------------
  // Operations and status flag positions
  // ---------------------------------------------------------------
  localparam logic [1:0] OP_READ   = 2'h0;
  localparam logic [1:0] OP_WRITE  = 2'h1;
  localparam logic [1:0] OP_FORMAT = 2'h2;
  localparam int         FL_BAD    = 0;
  localparam int         FL_CORR   = 1;
  localparam int         FL_UNCORR = 2;
  localparam int         FL_W      = 3;

endpackage : stc_pkg

// ===== hdl/stc_track_ctrl.sv
// Striped track controller for two units of four spindles each, with full-track buffer.
`timescale 1ns/1ps

module stc_track_ctrl (
  // Clock, reset, enable
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic                           ce,
  // Host command
  input  wire logic                           cmd_valid,
  input  wire logic [1:0]                     cmd_op,
  input  wire logic                           cmd_unit,
  input  wire logic [stc_pkg::CYL_W-1:0]      cmd_cyl,
  input  wire logic [stc_pkg::HEAD_W-1:0]     cmd_head,
  input  wire logic [stc_pkg::SECT_W-1:0]     cmd_sect,
  input  wire logic [stc_pkg::SECT_W-1:0]     cmd_count,
  input  wire logic                           cmd_def_en,
  input  wire logic [stc_pkg::WOFF_W-1:0]     cmd_def_off,
  output logic                                cmd_ready,
  // Host write data
  input  wire logic                           hw_valid,
  input  wire logic [stc_pkg::WORD_W-1:0]     hw_data,
  output logic                                hw_ready,
  // Host read data
  output logic                                hr_valid,
  output logic [stc_pkg::WORD_W-1:0]          hr_data,
  input  wire logic                           hr_ready,
  // Host status
  output logic                                sts_valid,
  output logic [stc_pkg::STS_W-1:0]           sts_data,
  // Drive control
  output logic                                drv_start,
  output logic [1:0]                          drv_op,
  output logic [stc_pkg::SPIN_W-1:0]          drv_sel,
  output logic [stc_pkg::CYL_W-1:0]           drv_cyl,
  output logic [stc_pkg::HEAD_W-1:0]          drv_head,
  output logic [stc_pkg::PSECT_W-1:0]         drv_psect,
  output logic                                drv_def_en,
  output logic [stc_pkg::WOFF_W-1:0]          drv_def_off,
  input  wire logic                           drv_id_valid,
  input  wire logic                           drv_id_def_en,
  input  wire logic [stc_pkg::WOFF_W-1:0]     drv_id_def_off,
  input  wire logic                           drv_done,
  input  wire logic [stc_pkg::DST_W-1:0]      drv_status,
  // Drive write stream
  output logic                                dw_valid,
  output logic [stc_pkg::CW_W-1:0]            dw_data,
  input  wire logic                           dw_ready,
  // Drive read stream
  input  wire logic                           dr_valid,
  input  wire logic [stc_pkg::CW_W-1:0]       dr_data,
  output logic                                dr_ready
);

  // ---------------------------------------------------------------
  // Code functions
  // ---------------------------------------------------------------
  // Parity bits sit at power-of-two positions, bit 0 is overall parity.
  function automatic logic [6:0] stc_syndrome(input logic [71:0] c);
    logic [6:0] s;
    s = '0;
    for (int p = 1; p < stc_pkg::CW_W; p++) begin
      if (c[p]) s = s ^ 7'(p);
    end
    return s;
  endfunction : stc_syndrome

  function automatic logic [71:0] stc_encode(input logic [63:0] d);
    logic [71:0] c;
    logic [6:0]  s;
    int          k;
    c = '0;
    k = 0;
    for (int p = 1; p < stc_pkg::CW_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p] = d[k];
        k++;
      end
    end
    s = stc_syndrome(c);
    for (int b = 0; b < 7; b++) begin
      c[1 << b] = s[b];
    end
    c[0] = ^c[71:1];
    return c;
  endfunction : stc_encode

  // Returns corrected data; flags a repaired or an unrepairable word.
  function automatic logic [65:0] stc_decode(input logic [71:0] c);
    logic [71:0] f;
    logic [63:0] d;
    logic [6:0]  s;
    logic        corr;
    logic        bad;
    int          k;
    f    = c;
    s    = stc_syndrome(c);
    corr = 1'b0;
    bad  = 1'b0;
    if (^c) begin
      corr = 1'b1;
      if (s != '0) f[s] = ~f[s];
    end else if (s != '0) begin
      bad = 1'b1;
    end
    d = '0;
    k = 0;
    for (int p = 1; p < stc_pkg::CW_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[k] = f[p];
        k++;
      end
    end
    return {bad, corr, d};
  endfunction : stc_decode

  // ---------------------------------------------------------------
  // State and datapath registers
  // ---------------------------------------------------------------
  typedef enum {S_IDLE, S_HFILL, S_START, S_ID, S_XFER, S_WAIT,
                S_HDRAIN, S_STAT} stc_state_t;

  stc_state_t                    state_r;
  stc_state_t                    state_nxt;
  logic [1:0]                    op_r;
  logic                          unit_r;
  logic [stc_pkg::CYL_W-1:0]     cyl_r;
  logic [stc_pkg::HEAD_W-1:0]    head_r;
  logic [stc_pkg::SECT_W-1:0]    sect_r;
  logic [stc_pkg::SECT_W-1:0]    first_r;
  logic [stc_pkg::SECT_W-1:0]    last_r;
  logic                          fdef_en_r;
  logic [stc_pkg::WOFF_W-1:0]    fdef_off_r;
  logic                          def_en_r;
  logic [stc_pkg::WOFF_W-1:0]    def_off_r;
  logic [stc_pkg::BEAT_W-1:0]    bcnt_r;
  logic [stc_pkg::ADDR_W-1:0]    hptr_r;
  logic [stc_pkg::FL_W-1:0]      flags_r;
  logic [stc_pkg::DST_W-1:0]     dstat_r;
  logic [stc_pkg::WORD_W-1:0]    buf_mem [stc_pkg::TRACK_WORDS];

  logic                          cmd_ok;
  logic [stc_pkg::SECT_W:0]      cmd_end;
  logic [stc_pkg::BEAT_W-1:0]    nbeats;
  logic [stc_pkg::BEAT_W-1:0]    def_lo;
  logic [stc_pkg::BEAT_W-1:0]    def_hi;
  logic                          in_fill;
  logic [stc_pkg::BEAT_W-1:0]    widx;
  logic [stc_pkg::ADDR_W-1:0]    baddr;
  logic [stc_pkg::ADDR_W-1:0]    hend;
  logic                          dw_take;
  logic                          rd_take;
  logic                          hr_take;
  logic                          xfer_end;
  logic [65:0]                   dec;

  // ---------------------------------------------------------------
  // Command check and beat decode
  // ---------------------------------------------------------------
  assign cmd_end = {1'b0, cmd_sect} + {1'b0, cmd_count};
  assign cmd_ok  = (cmd_cyl < stc_pkg::NUM_CYL) &&
                   (cmd_head < stc_pkg::NUM_HEADS) &&
                   (cmd_count != '0) &&
                   (cmd_end <= stc_pkg::NUM_SECT) &&
                   (cmd_op != 2'h3);

  // Fill beats occupy the defect position and shift later words on.
  assign def_lo  = {1'b0, def_off_r};
  assign def_hi  = def_lo + stc_pkg::FILL_BEATS;
  assign nbeats  = def_en_r ? stc_pkg::BLK_WORDS + stc_pkg::FILL_BEATS
                            : stc_pkg::BLK_WORDS;
  assign in_fill = def_en_r && (bcnt_r >= def_lo) &&
                   (bcnt_r < def_hi);
  assign widx    = (def_en_r && (bcnt_r >= def_hi))
                   ? bcnt_r - stc_pkg::FILL_BEATS : bcnt_r;
  assign baddr   = {sect_r, widx[stc_pkg::WOFF_W-1:0]};
  assign hend    = {6'(last_r + 6'h01), {stc_pkg::WOFF_W{1'b0}}};
  assign dec     = stc_decode(dr_data);

  assign cmd_ready = (state_r == S_IDLE);
  assign hw_ready  = (state_r == S_HFILL) && (hptr_r != hend);
  assign dr_ready  = (state_r == S_XFER) && (op_r == stc_pkg::OP_READ) &&
                     (bcnt_r < nbeats);
  assign rd_take   = dr_ready && dr_valid;
  assign dw_take   = (state_r == S_XFER) &&
                     (op_r == stc_pkg::OP_WRITE) &&
                     (bcnt_r < nbeats) && (!dw_valid || dw_ready);
  assign hr_take   = (state_r == S_HDRAIN) && (hptr_r != hend) &&
                     (!hr_valid || hr_ready);
  assign xfer_end  = (bcnt_r == nbeats) &&
                     ((op_r == stc_pkg::OP_READ) || !dw_valid);

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (cmd_valid && !cmd_ok) state_nxt = S_STAT;
        else if (cmd_valid && cmd_op == stc_pkg::OP_WRITE)
          state_nxt = S_HFILL;
        else if (cmd_valid) state_nxt = S_START;
      end
      S_HFILL:  if (hptr_r == hend) state_nxt = S_START;
      S_START: begin
        if (op_r == stc_pkg::OP_FORMAT) state_nxt = S_WAIT;
        else state_nxt = S_ID;
      end
      S_ID:     if (drv_id_valid) state_nxt = S_XFER;
      S_XFER:   if (xfer_end) state_nxt = S_WAIT;
      S_WAIT: begin
        if (drv_done && sect_r != last_r) state_nxt = S_START;
        else if (drv_done && op_r == stc_pkg::OP_READ)
          state_nxt = S_HDRAIN;
        else if (drv_done) state_nxt = S_STAT;
      end
      S_HDRAIN: begin
        if (hptr_r == hend && (!hr_valid || hr_ready))
          state_nxt = S_STAT;
      end
      S_STAT:   state_nxt = S_IDLE;
      default:  state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) state_r <= S_IDLE;
    else if (ce) state_r <= state_nxt;
  end

  // ---------------------------------------------------------------
  // Command latch and sector walk
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      op_r       <= stc_pkg::OP_READ;
      unit_r     <= 1'b0;
      cyl_r      <= '0;
      head_r     <= '0;
      sect_r     <= '0;
      first_r    <= '0;
      last_r     <= '0;
      fdef_en_r  <= 1'b0;
      fdef_off_r <= '0;
    end else if (ce) begin
      if (state_r == S_IDLE && cmd_valid && cmd_ok) begin
        op_r       <= cmd_op;
        unit_r     <= cmd_unit;
        cyl_r      <= cmd_cyl;
        head_r     <= cmd_head;
        sect_r     <= cmd_sect;
        first_r    <= cmd_sect;
        last_r     <= 6'(cmd_end - 7'h01);
        fdef_en_r  <= cmd_def_en;
        fdef_off_r <= cmd_def_off;
      end else if (state_r == S_WAIT && drv_done && sect_r != last_r) begin
        sect_r <= sect_r + 6'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // Drive control and status return
  // ---------------------------------------------------------------
  // Logical sector s maps to spindle unit*4 + s/12, physical sector s%12.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drv_start   <= 1'b0;
      drv_op      <= stc_pkg::OP_READ;
      drv_sel     <= '0;
      drv_cyl     <= '0;
      drv_head    <= '0;
      drv_psect   <= '0;
      drv_def_en  <= 1'b0;
      drv_def_off <= '0;
      dstat_r     <= '0;
    end else if (ce) begin
      drv_start <= (state_r == S_START);
      if (state_r == S_START) begin
        drv_op      <= op_r;
        drv_sel     <= 3'({2'h0, unit_r} * stc_pkg::SPIN_PER_UNIT) +
                       3'(sect_r / stc_pkg::SECT_PER_SPIN);
        drv_psect   <= 4'(sect_r % stc_pkg::SECT_PER_SPIN);
        drv_cyl     <= cyl_r;
        drv_head    <= head_r;
        drv_def_en  <= fdef_en_r;
        drv_def_off <= fdef_off_r;
      end
      if (state_r == S_WAIT && drv_done) dstat_r <= drv_status;
    end
  end

  // ---------------------------------------------------------------
  // Sector beat counter and defect window
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bcnt_r    <= '0;
      def_en_r  <= 1'b0;
      def_off_r <= '0;
    end else if (ce) begin
      if (state_r == S_ID && drv_id_valid) begin
        bcnt_r    <= '0;
        def_en_r  <= drv_id_def_en;
        def_off_r <= drv_id_def_off;
      end else if (dw_take || rd_take) begin
        bcnt_r <= bcnt_r + 10'h001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Drive write stream
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dw_valid <= 1'b0;
      dw_data  <= '0;
    end else if (ce) begin
      if (dw_take) begin
        dw_valid <= 1'b1;
        if (in_fill) dw_data <= '0;
        else dw_data <= stc_encode(buf_mem[baddr]);
      end else if (dw_ready) begin
        dw_valid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Track buffer and host pointer
  // ---------------------------------------------------------------
  // No reset on the buffer: it is plain storage, and resetting it
  // would cost a load on every one of its flip-flops.
  always_ff @(posedge clk) begin
    if (ce) begin
      if (hw_ready && hw_valid) buf_mem[hptr_r] <= hw_data;
      else if (rd_take && !in_fill)
        buf_mem[baddr] <= dec[stc_pkg::WORD_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hptr_r <= '0;
    end else if (ce) begin
      if (state_r == S_IDLE && cmd_valid)
        hptr_r <= {cmd_sect, {stc_pkg::WOFF_W{1'b0}}};
      else if (state_r == S_WAIT && state_nxt == S_HDRAIN)
        hptr_r <= {first_r, {stc_pkg::WOFF_W{1'b0}}};
      else if ((hw_ready && hw_valid) || hr_take)
        hptr_r <= hptr_r + 15'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Host read stream
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hr_valid <= 1'b0;
      hr_data  <= '0;
    end else if (ce) begin
      if (hr_take) begin
        hr_valid <= 1'b1;
        hr_data  <= buf_mem[hptr_r];
      end else if (hr_ready) begin
        hr_valid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Error flags and host status
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_r   <= '0;
      sts_valid <= 1'b0;
      sts_data  <= '0;
    end else if (ce) begin
      if (state_r == S_IDLE && cmd_valid) begin
        flags_r <= '0;
        flags_r[stc_pkg::FL_BAD] <= !cmd_ok;
      end else if (rd_take && !in_fill) begin
        if (dec[64]) flags_r[stc_pkg::FL_CORR] <= 1'b1;
        if (dec[65]) flags_r[stc_pkg::FL_UNCORR] <= 1'b1;
      end
      sts_valid <= (state_r == S_STAT);
      if (state_r == S_STAT)
        sts_data <= {5'h00, flags_r, dstat_r};
    end
  end

  // Fill beats are neither stored nor flagged: they cover flawed media.

endmodule : stc_track_ctrl

// ===== verif/stc_drive_model.sv
// Behavioural drive unit answering one sector operation at a time.
`timescale 1ns/1ps
module stc_drive_model (
  // Clock and reset
  input wire logic                       clk,
  input wire logic                       rst,
  // Control
  input wire logic                       drv_start,
  input wire logic [1:0]                 drv_op,
  input wire logic                       drv_def_en,
  input wire logic [stc_pkg::WOFF_W-1:0] drv_def_off,
  output logic                           drv_id_valid,
  output logic                           drv_id_def_en,
  output logic [stc_pkg::WOFF_W-1:0]     drv_id_def_off,
  output logic                           drv_done,
  output logic [stc_pkg::DST_W-1:0]      drv_status,
  // Streams
  input wire logic                       dw_valid,
  input wire logic [stc_pkg::CW_W-1:0]   dw_data,
  output logic                           dw_ready,
  output logic                           dr_valid,
  output logic [stc_pkg::CW_W-1:0]       dr_data,
  input wire logic                       dr_ready,
  // Bench controls
  input wire logic                       flip,
  input wire logic [stc_pkg::DST_W-1:0]  st_in
);
  logic [stc_pkg::CW_W-1:0]   mem [0:513];
  logic                       def_en_r;
  logic [stc_pkg::WOFF_W-1:0] def_off_r;
  int                         n_got;
  int                         n;

  // Only one sector image is kept, so read-back must follow its write.
  initial begin
    {drv_id_valid, drv_id_def_en, drv_done, dw_ready, dr_valid} = '0;
    drv_id_def_off = '0;
    drv_status = '0;
    dr_data = '0;
    def_en_r = 1'b0;
    def_off_r = '0;
    n_got = 0;
    forever begin
      @(posedge clk);
      if (drv_start === 1'b1 && !rst) begin
        if (drv_op == stc_pkg::OP_FORMAT) begin
          def_en_r = drv_def_en;
          def_off_r = drv_def_off;
        end
        repeat (3) @(posedge clk);
        #2 drv_id_valid = 1'b1;
        drv_id_def_en = def_en_r;
        drv_id_def_off = def_off_r;
        @(posedge clk);
        #2 drv_id_valid = 1'b0;
        drv_id_def_en = ~def_en_r;
        drv_id_def_off = ~def_off_r;
        n = def_en_r ? 514 : 512;
        if (drv_op == stc_pkg::OP_WRITE) begin
          n_got = 0;
          while (n_got < n) begin
            dw_ready = ~dw_ready;
            @(posedge clk);
            if (dw_valid === 1'b1 && dw_ready) begin
              mem[n_got] = dw_data;
              n_got++;
            end
            #2;
          end
          dw_ready = 1'b0;
        end else if (drv_op == stc_pkg::OP_READ) begin
          for (int i = 0; i < n; i++) begin
            dr_valid = 1'b1;
            dr_data = mem[i] ^ ((flip && i == 7) ? 72'h400 : 72'h0);
            do @(posedge clk); while (dr_ready !== 1'b1);
            #2;
          end
          dr_valid = 1'b0;
          dr_data = ~dr_data;
        end
        repeat (2) @(posedge clk);
        #2 drv_done = 1'b1;
        drv_status = st_in;
        @(posedge clk);
        #2 drv_done = 1'b0;
        drv_status = ~st_in;
      end
    end
  end
endmodule : stc_drive_model

// ===== verif/stc_track_ctrl_assertions.sv
// Port checker for the striped track controller.
`timescale 1ns/1ps
module stc_track_ctrl_assertions (
  // Clock, reset, enable
  input wire logic                        clk,
  input wire logic                        rst,
  input wire logic                        ce,
  // Command and status
  input wire logic                        cmd_valid,
  input wire logic [1:0]                  cmd_op,
  input wire logic [stc_pkg::CYL_W-1:0]   cmd_cyl,
  input wire logic [stc_pkg::HEAD_W-1:0]  cmd_head,
  input wire logic                        cmd_ready,
  input wire logic                        sts_valid,
  input wire logic [stc_pkg::STS_W-1:0]   sts_data,
  // Drive side
  input wire logic                        drv_start,
  input wire logic [stc_pkg::CYL_W-1:0]   drv_cyl,
  input wire logic [stc_pkg::HEAD_W-1:0]  drv_head,
  input wire logic [stc_pkg::PSECT_W-1:0] drv_psect,
  input wire logic                        dw_valid,
  input wire logic [stc_pkg::CW_W-1:0]    dw_data,
  input wire logic                        dw_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence take_s;
    cmd_valid && cmd_ready && ce;
  endsequence
  sequence bad_s;
    take_s ##0 (cmd_cyl >= stc_pkg::NUM_CYL ||
      cmd_head >= stc_pkg::NUM_HEADS || cmd_op == 2'h3);
  endsequence

  AST_BAD_STS: assert property (bad_s |-> ##[1:3] (sts_valid && sts_data[8]))
    else $error("bad command not flagged");
  AST_BAD_QUIET: assert property (bad_s |=> !drv_start [*3])
    else $error("bad command reached the drive");
  AST_BUSY: assert property (take_s |=> !cmd_ready)
    else $error("command taken while busy");
  AST_RDY_BACK: assert property (sts_valid && ce |-> cmd_ready)
    else $error("not idle after status");
  AST_STS_PULSE: assert property (sts_valid |=> !sts_valid)
    else $error("status longer than one cycle");
  AST_GEOM: assert property (drv_start |-> drv_psect < 4'hC &&
    drv_cyl < stc_pkg::NUM_CYL && drv_head < stc_pkg::NUM_HEADS)
    else $error("drive address out of range");
  AST_START_PULSE: assert property ($rose(drv_start) |=> $fell(drv_start))
    else $error("start longer than one cycle");
  AST_DW_HOLD: assert property (dw_valid && !dw_ready |=>
    dw_valid && $stable(dw_data))
    else $error("write codeword dropped or changed");
  AST_IDLE_QUIET: assert property (cmd_ready |-> !dw_valid && !drv_start)
    else $error("drive activity while idle");
endmodule : stc_track_ctrl_assertions

bind stc_track_ctrl stc_track_ctrl_assertions stc_track_ctrl_assertions_i (
  .clk, .rst, .ce, .cmd_valid, .cmd_op, .cmd_cyl, .cmd_head, .cmd_ready,
  .sts_valid, .sts_data, .drv_start, .drv_cyl, .drv_head, .drv_psect,
  .dw_valid, .dw_data, .dw_ready);

// ===== verif/stc_track_ctrl_tb_top.sv
// Self-checking bench for the striped track controller.
`timescale 1ns/1ps
module stc_track_ctrl_tb_top;
  logic clk, rst, ce, cmd_valid, cmd_unit, cmd_def_en, cmd_ready, flip;
  logic hw_valid, hw_ready, hr_valid, hr_ready, sts_valid, drv_start;
  logic drv_def_en, drv_id_valid, drv_id_def_en, drv_done, dw_valid;
  logic dw_ready, dr_valid, dr_ready;
  logic [1:0] cmd_op, drv_op;
  logic [10:0] cmd_cyl, drv_cyl;
  logic [3:0] cmd_head, drv_head, drv_psect, last_psect;
  logic [5:0] cmd_sect, cmd_count;
  logic [8:0] cmd_def_off, drv_def_off, drv_id_def_off, last_off;
  logic [63:0] hw_data, hr_data;
  logic [15:0] sts_data;
  logic [2:0] drv_sel, last_sel;
  logic [7:0] drv_status, st_in;
  logic [71:0] dw_data, dr_data;
  logic [1:0] last_op;
  logic [14:0] last_ch;
  int num_errors = 0;
  int n_checks = 0;
  int starts = 0;
  int cyc = 0;

  stc_track_ctrl stc_track_ctrl_i (.clk, .rst, .ce, .cmd_valid, .cmd_op,
    .cmd_unit, .cmd_cyl, .cmd_head, .cmd_sect, .cmd_count, .cmd_def_en,
    .cmd_def_off, .cmd_ready, .hw_valid, .hw_data, .hw_ready, .hr_valid,
    .hr_data, .hr_ready, .sts_valid, .sts_data, .drv_start, .drv_op,
    .drv_sel, .drv_cyl, .drv_head, .drv_psect, .drv_def_en, .drv_def_off,
    .drv_id_valid, .drv_id_def_en, .drv_id_def_off, .drv_done, .drv_status,
    .dw_valid, .dw_data, .dw_ready, .dr_valid, .dr_data, .dr_ready);
  stc_drive_model stc_drive_model_i (.clk, .rst, .drv_start, .drv_op,
    .drv_def_en, .drv_def_off, .drv_id_valid, .drv_id_def_en,
    .drv_id_def_off, .drv_done, .drv_status, .dw_valid, .dw_data,
    .dw_ready, .dr_valid, .dr_data, .dr_ready, .flip, .st_in);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // A run of a few thousand cycles is expected; the ceiling is generous.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (drv_start === 1'b1) begin
      starts <= starts + 1;
      {last_sel, last_psect, last_op, last_off, last_ch} <=
        {drv_sel, drv_psect, drv_op, drv_def_off, drv_cyl, drv_head};
    end
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end

  function automatic logic [63:0] pat(input int i);
    return {32'hC0DE_0000 ^ 32'(i), 32'(i) * 32'h0000_0101};
  endfunction : pat

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic send_cmd(input logic [1:0] op, input logic [10:0] cyl,
      input logic [3:0] hd, input logic [5:0] sc, input logic [5:0] cn);
    {cmd_op, cmd_cyl, cmd_head, cmd_sect, cmd_count} = {op, cyl, hd, sc, cn};
    cmd_valid = 1'b1;
    do @(posedge clk); while (cmd_ready !== 1'b1);
    #2 cmd_valid = 1'b0;
  endtask : send_cmd

  task automatic wait_sts(output logic [15:0] s);
    int k;
    k = 0;
    while (sts_valid !== 1'b1 && k < 8000) begin
      @(posedge clk);
      #2 k++;
    end
    chk(64'(sts_valid), 64'h1);
    s = sts_data;
  endtask : wait_sts

  task automatic t_bad;
    logic [15:0] s;
    int b;
    for (int c = 0; c < 4; c++) begin
      b = starts;
      send_cmd(c == 2 ? 2'h3 : stc_pkg::OP_READ,
        c == 0 ? stc_pkg::NUM_CYL : 11'h000,
        c == 1 ? stc_pkg::NUM_HEADS : 4'h0, 6'h00, c == 3 ? 6'h00 : 6'h01);
      wait_sts(s);
      chk(64'(s[8]), 64'h1);
      chk(64'(starts - b), 64'h0);
    end
  endtask : t_bad

  task automatic t_format;
    logic [15:0] s;
    int b;
    b = starts;
    st_in = 8'h5C;
    send_cmd(stc_pkg::OP_FORMAT, 11'h010, 4'h3, 6'h0D, 6'h02);
    wait_sts(s);
    chk(64'(starts - b), 64'h2);
    chk(64'({last_op, last_sel, last_psect}), 64'h152);
    chk(64'(last_off), 64'h64);
    chk(64'(s[7:0]), 64'h5C);
  endtask : t_format

  task automatic t_write;
    logic [15:0] s;
    int i;
    flip = 1'b0;
    send_cmd(stc_pkg::OP_WRITE, 11'h662, 4'hE, 6'h2F, 6'h01);
    i = 0;
    hw_valid = 1'b1;
    hw_data = pat(0);
    while (i < 512 && cyc < 20000) begin
      @(posedge clk);
      if (hw_ready === 1'b1) i++;
      #2 hw_data = pat(i);
    end
    hw_valid = 1'b0;
    chk(64'(hw_ready), 64'h0);
    wait_sts(s);
    chk(64'(s[10:8]), 64'h0);
    chk(64'({last_sel, last_psect}), 64'h7B);
    chk(64'(last_ch), 64'h662E);
    chk(64'(stc_drive_model_i.n_got), 64'd514);
    chk(64'(|stc_drive_model_i.mem[100]), 64'h0);
    chk(64'(|stc_drive_model_i.mem[101]), 64'h0);
  endtask : t_write

  task automatic t_read;
    logic [15:0] s;
    int i, k;
    flip = 1'b1;
    send_cmd(stc_pkg::OP_READ, 11'h662, 4'hE, 6'h2F, 6'h01);
    i = 0;
    k = 0;
    while (sts_valid !== 1'b1 && k < 8000) begin
      hr_ready = k[0];
      @(posedge clk);
      if (hr_valid === 1'b1 && hr_ready) begin
        chk(hr_data, pat(i));
        i++;
      end
      #2 k++;
    end
    wait_sts(s);
    chk(64'(i), 64'd512);
    chk(64'(s[10:9]), 64'h1);
  endtask : t_read

  task automatic final_report;
    if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report

  initial begin
    {rst, ce, cmd_valid, cmd_unit, cmd_def_en} = 5'b1_1011;
    {hw_valid, hr_ready, flip} = '0;
    {cmd_op, cmd_cyl, cmd_head, cmd_sect, cmd_count} = '0;
    cmd_def_off = 9'h064;
    hw_data = '0;
    st_in = '0;
    repeat (4) @(posedge clk);
    #2 rst = 1'b0;
    t_bad();
    t_format();
    t_write();
    t_read();
    final_report();
  end
endmodule : stc_track_ctrl_tb_top
